// ---- logic/sfam_device.sv ----
// Self-programming unit: control register, page buffer, flash array.
// Assumes the core end keeps the command timing and polling protocol.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sfam_device #(
  parameter int PROG_CYCLES = sfam_pkg::PROG_MIN_CYCLES,
  parameter int FLASH_WORDS = 32768
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sys_resetn,
  input wire logic [1:0] boot_size_fuse,
  sfam_if.device link,
  output logic [14:0] boot_start,
  output logic [7:0] lock_bits
);
  // ==========================================================
  // Region decode
  function automatic logic in_concurrent(input logic [14:0] a);
    in_concurrent = a <= sfam_pkg::CONCURRENT_END;
  endfunction
  function automatic logic [14:0] boot_base(input logic [1:0] f);
    case (f)
      2'b11: boot_base = sfam_pkg::BOOT_START_11;
      2'b10: boot_base = sfam_pkg::BOOT_START_10;
      2'b01: boot_base = sfam_pkg::BOOT_START_01;
      default: boot_base = sfam_pkg::BOOT_START_00;
    endcase
  endfunction
  // ==========================================================
  // State
  typedef enum logic [2:0] {
    SFAM_IDLE = 3'b001,
    SFAM_ARMED = 3'b010,
    SFAM_PROG = 3'b100
  } sfam_phase_t;
  typedef struct packed {
    sfam_phase_t phase;
    logic [2:0] window;
    logic [6:0] cmd;
    logic busy;
    logic [7:0] page;
    logic [14:0] boot_start;
    logic [7:0] lock_bits;
    logic [15:0] fetch_data;
    logic fetch_blocked;
    logic [7:0] ctrl;
  } sfam_dev_t;
  sfam_dev_t state;
  sfam_dev_t next_state;
  logic [15:0] buffer [sfam_pkg::PAGE_WORDS];
  logic [sfam_pkg::PAGE_WORDS-1:0] buf_valid;
  logic [15:0] flash [FLASH_WORDS];
  logic timer_start;
  logic timer_running;
  logic timer_done;
  logic rst_s1;
  logic rst_s2;
  logic [7:0] z_page;
  logic [6:0] z_word;
  logic [14:0] rd_addr;
  logic cmd_ok;
  logic clear_buf;
  // Sync the system reset; it only touches core-facing state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= sys_resetn;
      rst_s2 <= rst_s1;
    end
  end
  assign z_page = link.pointer[sfam_pkg::POINTER_PC_TOP_BIT:8];
  assign z_word = link.pointer[sfam_pkg::POINTER_PAGE_WORD_TOP_BIT:1];
  assign rd_addr = link.pointer[15:1];
  // Commands with pointer bit 0 set are not honoured
  assign cmd_ok = link.store && !link.pointer[0];
  sfam_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(timer_start),
    .running(timer_running),
    .done(timer_done)
  );
  // ==========================================================
  // Control sequence
  always_comb begin
    next_state = state;
    timer_start = 1'b0;
    clear_buf = 1'b0;
    next_state.boot_start = boot_base(boot_size_fuse);
    case (state.phase)
      SFAM_IDLE: begin
        if (link.ctrl_wr && !link.eeprom_write_busy
            && link.ctrl_wdata[sfam_pkg::EN_BIT]) begin
          next_state.cmd = link.ctrl_wdata[6:0];
          next_state.window = 3'(sfam_pkg::STORE_WINDOW_CYCLES);
          next_state.phase = SFAM_ARMED;
        end
      end
      SFAM_ARMED: begin
        if (cmd_ok) begin
          next_state.page = z_page;
          case (state.cmd)
            sfam_pkg::CMD_LOAD: next_state.phase = SFAM_IDLE;
            sfam_pkg::CMD_ERASE, sfam_pkg::CMD_WRITE,
            sfam_pkg::CMD_LOCK: begin
              timer_start = 1'b1;
              next_state.phase = SFAM_PROG;
              if (state.cmd != sfam_pkg::CMD_LOCK) begin
                next_state.busy = 1'b1;
              end
            end
            sfam_pkg::CMD_REENABLE: begin
              next_state.busy = 1'b0;
              clear_buf = 1'b1;
              next_state.phase = SFAM_IDLE;
            end
            default: next_state.phase = SFAM_IDLE;
          endcase
        end else if (state.window == 3'h1) begin
          next_state.phase = SFAM_IDLE;
        end else begin
          next_state.window = state.window - 3'h1;
        end
      end
      SFAM_PROG: begin
        // Enable stays high until the timer ends
        if (timer_done) begin
          next_state.phase = SFAM_IDLE;
          if (state.cmd == sfam_pkg::CMD_WRITE) begin
            clear_buf = 1'b1;
          end
          if (state.cmd == sfam_pkg::CMD_LOCK) begin
            next_state.lock_bits = link.store_data[7:0] & state.lock_bits;
          end
        end
      end
      default: next_state.phase = SFAM_IDLE;
    endcase
    // Blocked region reads give a constant and never stop the timer
    next_state.fetch_blocked = link.fetch && state.busy
      && in_concurrent(rd_addr);
    if (next_state.fetch_blocked) begin
      next_state.fetch_data = sfam_pkg::BLOCKED_READ_VALUE;
    end else if (link.pointer[0]) begin
      next_state.fetch_data = {8'h00, flash[rd_addr][15:8]};
    end else begin
      next_state.fetch_data = {8'h00, flash[rd_addr][7:0]};
    end
    next_state.ctrl = {1'b0, next_state.busy, 1'b0,
      (next_state.phase == SFAM_IDLE) ? 5'h00 : next_state.cmd[4:0]};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '{phase: SFAM_IDLE, lock_bits: 8'hFF,
                 ctrl: sfam_pkg::CTRL_RESET, default: '0};
    end else if (!rst_s2 && state.phase != SFAM_PROG) begin
      state <= '{phase: SFAM_IDLE, lock_bits: state.lock_bits,
                 busy: 1'b0, boot_start: next_state.boot_start,
                 ctrl: sfam_pkg::CTRL_RESET, default: '0};
    end else begin
      // A running erase or lock rides through system reset; a write runs on with buf_valid cleared, so it programs 16'hFFFF
      state <= next_state;
    end
  end
  // ==========================================================
  // Page buffer and array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_valid <= '0;
    end else if (clear_buf || !rst_s2) begin
      buf_valid <= '0;
    end else if (state.phase == SFAM_ARMED && cmd_ok
                 && state.cmd == sfam_pkg::CMD_LOAD
                 && !buf_valid[z_word]) begin
      buf_valid[z_word] <= 1'b1;
    end
  end
  always_ff @(posedge pclk) begin
    if (state.phase == SFAM_ARMED && cmd_ok
        && state.cmd == sfam_pkg::CMD_LOAD && !buf_valid[z_word]) begin
      buffer[z_word] <= link.store_data;
    end
    if (timer_done) begin
      for (int i = 0; i < sfam_pkg::PAGE_WORDS; i++) begin
        if (state.cmd == sfam_pkg::CMD_ERASE) begin
          flash[{state.page, 7'(i)}] <= 16'hFFFF;
        end else if (state.cmd == sfam_pkg::CMD_WRITE) begin
          flash[{state.page, 7'(i)}] <= buf_valid[i] ? buffer[i] : 16'hFFFF;
        end
      end
    end
  end
  assign link.selfprog_ctrl_status_reg = state.ctrl;
  assign link.fetch_data = state.fetch_data;
  assign link.fetch_blocked = state.fetch_blocked;
  assign boot_start = state.boot_start;
  assign lock_bits = state.lock_bits;
endmodule
`default_nettype wire

// ---- logic/sfam_pkg.sv ----
// Shared constants for the self-programming flash address map.
// Assumes a single 100 MHz clock domain shared by both ends.
`default_nettype none
package sfam_pkg;
  // ==========================================================
  // Address geometry
  localparam int PC_W = 15;
  localparam int PC_TOP_BIT = 14;
  localparam int PAGE_WORD_TOP_BIT = 6;
  localparam int POINTER_PC_TOP_BIT = 15;
  localparam int POINTER_PAGE_WORD_TOP_BIT = 7;
  localparam int PAGE_WORDS = 128;
  localparam int PAGE_IDX_W = 8;
  localparam int WORD_IDX_W = 7;
  // ==========================================================
  // Regions
  localparam logic [14:0] BLOCKING_START = 15'h7000;
  localparam logic [14:0] CONCURRENT_END = 15'h6FFF;
  localparam int CONCURRENT_PAGES = 224;
  localparam int BLOCKING_PAGES = 32;
  localparam logic [14:0] BOOT_START_11 = 15'h7E00;
  localparam logic [14:0] BOOT_START_10 = 15'h7C00;
  localparam logic [14:0] BOOT_START_01 = 15'h7800;
  localparam logic [14:0] BOOT_START_00 = 15'h7000;
  localparam logic [15:0] BLOCKED_READ_VALUE = 16'hFFFF;
  // ==========================================================
  // Control register bits and commands
  localparam int EN_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_BIT = 3;
  localparam int REENABLE_BIT = 4;
  localparam int BUSY_BIT = 6;
  localparam logic [6:0] CMD_LOAD = 7'h01;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_LOCK = 7'h09;
  localparam logic [6:0] CMD_REENABLE = 7'h11;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ==========================================================
  // Timing
  localparam int STORE_WINDOW_CYCLES = 4;
  localparam real CLK_MHZ = 100.0;
  localparam real PROG_MIN_MS = 3.7;
  localparam real PROG_MAX_MS = 4.5;
  localparam int PROG_MIN_CYCLES = int'($ceil(PROG_MIN_MS * 1000.0 * CLK_MHZ));
  localparam int PROG_MAX_CYCLES = int'($floor(PROG_MAX_MS * 1000.0 * CLK_MHZ));
  // ==========================================================
  // Host-side APB register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_POINTER = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_READ = 8'h10;
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_TIMEOUT = 2;
endpackage
`default_nettype wire

// ---- logic/sfam_if.sv ----
// Link between the self-programming unit and the boot loader core.
// Assumes both ends share pclk and presetn.
`timescale 1ns/1ps
`default_nettype none
interface sfam_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] selfprog_ctrl_status_reg;
  logic store;
  logic [15:0] pointer;
  logic [15:0] store_data;
  logic fetch;
  logic [15:0] fetch_data;
  logic fetch_blocked;
  logic eeprom_write_busy;
  modport device (
    input ctrl_wr, ctrl_wdata, store, pointer, store_data, fetch,
    input eeprom_write_busy,
    output selfprog_ctrl_status_reg, fetch_data, fetch_blocked
  );
  modport core (
    output ctrl_wr, ctrl_wdata, store, pointer, store_data, fetch,
    output eeprom_write_busy,
    input selfprog_ctrl_status_reg, fetch_data, fetch_blocked
  );
endinterface
`default_nettype wire

// ---- logic/sfam_timer.sv ----
// Programming-time counter for erase, write and lock-bit write.
// Assumes start pulses arrive only while idle.
`timescale 1ns/1ps
`default_nettype none
module sfam_timer #(
  parameter int CYCLES = sfam_pkg::PROG_MIN_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic running,
  output logic done
);
  typedef struct packed {
    logic [22:0] count;
    logic running;
    logic done;
  } sfam_tmr_t;
  sfam_tmr_t state;
  sfam_tmr_t next_state;
  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (start && !state.running) begin
      next_state.running = 1'b1;
      next_state.count = 23'(CYCLES - 1);
    end else if (state.running) begin
      if (state.count == 23'h0) begin
        next_state.running = 1'b0;
        next_state.done = 1'b1;
      end else begin
        next_state.count = state.count - 23'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign running = state.running;
  assign done = state.done;
endmodule
`default_nettype wire

// ---- logic/sfam_core.sv ----
// Boot loader core end: APB-driven command issuer.
// Assumes the device end answers per the shared link protocol.
`timescale 1ns/1ps
`default_nettype none
module sfam_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeprom_busy_in,
  sfam_if.core link
);
  typedef enum logic [3:0] {
    SFAM_C_IDLE = 4'b0001,
    SFAM_C_POLL = 4'b0010,
    SFAM_C_CTRL = 4'b0100,
    SFAM_C_STORE = 4'b1000
  } sfam_cst_t;
  typedef struct packed {
    sfam_cst_t st;
    logic [7:0] cmd;
    logic [15:0] pointer;
    logic [15:0] data;
    logic done;
    logic ctrl_wr;
    logic store;
    logic fetch;
    logic [31:0] prdata;
    logic pslverr;
    logic pready;
    logic [1:0] wait_cnt;
    logic ee1;
    logic ee2;
  } sfam_core_t;
  sfam_core_t s;
  sfam_core_t next_s;
  logic setup;
  logic acc;
  assign setup = psel && !penable;
  assign acc = psel && penable;
  always_comb begin
    next_s = s;
    next_s.ctrl_wr = 1'b0;
    next_s.store = 1'b0;
    next_s.fetch = 1'b0;
    next_s.pready = 1'b0;
    next_s.ee1 = eeprom_busy_in;
    next_s.ee2 = s.ee1;
    // ========================================================
    // Issue sequence
    case (s.st)
      SFAM_C_POLL: begin
        // Wait for enable clear and EEPROM idle
        // Both stages idle, so the link flag cannot rise with ctrl_wr
        if (!link.selfprog_ctrl_status_reg[sfam_pkg::EN_BIT] && !s.ee2
            && !s.ee1) begin
          next_s.ctrl_wr = 1'b1;
          next_s.st = SFAM_C_CTRL;
        end
      end
      SFAM_C_CTRL: begin
        next_s.store = 1'b1;
        next_s.st = SFAM_C_STORE;
      end
      SFAM_C_STORE: begin
        next_s.done = 1'b1;
        next_s.st = SFAM_C_IDLE;
      end
      default: next_s.st = SFAM_C_IDLE;
    endcase
    // ========================================================
    // Error and every answer but the array read settle in setup, so both leave flops
    if (setup) begin
      next_s.pslverr = 1'b0;
      next_s.pready = 1'b1;
      next_s.wait_cnt = 2'h0;
      if (pwrite) begin
        case (paddr)
          // A second command while one is pending is refused
          sfam_pkg::OFS_CMD: next_s.pslverr = s.st != SFAM_C_IDLE;
          sfam_pkg::OFS_POINTER: next_s.pslverr = 1'b0;
          sfam_pkg::OFS_DATA: next_s.pslverr = 1'b0;
          default: next_s.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          sfam_pkg::OFS_STATUS: next_s.prdata = {16'h0000,
            link.selfprog_ctrl_status_reg, 5'h00, s.ee2,
            s.st != SFAM_C_IDLE, s.done};
          // Busy flag read lets software avoid the region
          sfam_pkg::OFS_READ: begin
            // Array answer lags the fetch: two wait states
            next_s.fetch = 1'b1;
            next_s.pready = 1'b0;
            next_s.wait_cnt = 2'h2;
          end
          sfam_pkg::OFS_POINTER: next_s.prdata = {16'h0000, s.pointer};
          default: begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b1;
          end
        endcase
      end
    end else if (acc && !s.pready) begin
      if (s.wait_cnt == 2'h1) begin
        next_s.prdata = {15'h0000, link.fetch_blocked, link.fetch_data};
        next_s.pready = 1'b1;
      end
      if (s.wait_cnt != 2'h0) begin
        next_s.wait_cnt = s.wait_cnt - 2'h1;
      end
    end else if (acc && pwrite && !s.pslverr) begin
      // Write lands on the edge that samples pready high
      case (paddr)
        sfam_pkg::OFS_CMD: begin
          next_s.cmd = pwdata[7:0];
          next_s.done = 1'b0;
          next_s.st = SFAM_C_POLL;
        end
        // Software keeps bit 0 and word index zero where needed
        sfam_pkg::OFS_POINTER: next_s.pointer = pwdata[15:0];
        sfam_pkg::OFS_DATA: next_s.data = pwdata[15:0];
        default: next_s.data = s.data;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: SFAM_C_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign link.ctrl_wr = s.ctrl_wr;
  assign link.ctrl_wdata = s.cmd;
  assign link.store = s.store;
  assign link.pointer = s.pointer;
  assign link.store_data = s.data;
  assign link.fetch = s.fetch;
  assign link.eeprom_write_busy = s.ee2;
endmodule
`default_nettype wire

// ---- verif/sfam_checker_sva.sv ----
// Concurrent checks on the link between core end and device end.
// Assumes one clock, pclk, and presetn as async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfam_checker #(
  parameter int PROG_CYCLES = sfam_pkg::PROG_MIN_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] selfprog_ctrl_status_reg,
  input wire logic store,
  input wire logic [15:0] pointer,
  input wire logic [15:0] fetch_data,
  input wire logic fetch_blocked,
  input wire logic eeprom_write_busy
);
  // =====
  // Programming-time counter
  logic en;
  logic busy;
  logic run;
  int cnt;
  assign en = selfprog_ctrl_status_reg[sfam_pkg::EN_BIT];
  assign busy = selfprog_ctrl_status_reg[sfam_pkg::BUSY_BIT];
  // Counts from the store, so a late timer start shows up too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'h0;
      cnt <= 0;
    end else if (store && selfprog_ctrl_status_reg[3:1] != 3'h0) begin
      run <= 1'h1;
      cnt <= 1;
    end else if (run && !en) begin
      run <= 1'h0;
    end else if (run) begin
      cnt <= cnt + 1;
    end
  end
  // =====
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_prog_len;
    run && !en |-> cnt >= PROG_CYCLES && cnt <= PROG_CYCLES + 3;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("programming time out of range");
  property p_blocked_val;
    fetch_blocked |-> fetch_data == sfam_pkg::BLOCKED_READ_VALUE;
  endproperty
  a_blocked_val: assert property (p_blocked_val)
    else $error("blocked read value wrong");
  property p_blocked_busy;
    $rose(fetch_blocked) |-> $past(busy);
  endproperty
  a_blocked_busy: assert property (p_blocked_busy)
    else $error("read blocked while region idle");
  property p_busy_hold;
    $fell(busy) |-> $past(store) || $past(store, 2);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy flag cleared without command");
  property p_en_first;
    ctrl_wr |-> !en;
  endproperty
  a_en_first: assert property (p_en_first)
    else $error("command issued while enable set");
  property p_ee_idle;
    ctrl_wr |-> !eeprom_write_busy;
  endproperty
  a_ee_idle: assert property (p_ee_idle)
    else $error("command issued during eeprom write");
  property p_ptr_even;
    store |-> !pointer[0];
  endproperty
  a_ptr_even: assert property (p_ptr_even)
    else $error("store with odd pointer");
  property p_write_word0;
    store && selfprog_ctrl_status_reg[sfam_pkg::WRITE_BIT] |->
      pointer[7:1] == 7'h00;
  endproperty
  a_write_word0: assert property (p_write_word0)
    else $error("page write with nonzero word index");
  property p_store_soon;
    ctrl_wr |-> ##[1:4] store;
  endproperty
  a_store_soon: assert property (p_store_soon)
    else $error("store late after command");
  property p_lapse;
    ctrl_wr ##0 (!store) [*6] |-> !en;
  endproperty
  a_lapse: assert property (p_lapse)
    else $error("command did not lapse");
  cover property (ctrl_wr && ctrl_wdata[2:0] == 3'h5);
  cover property ($rose(fetch_blocked));
  cover property ($fell(busy));
endmodule
`default_nettype wire

// ---- verif/selfprog_flash_addr_map_tb.sv ----
// Bench: core end driven over APB, device end on the shared link.
// Assumes a short programming count in the device end.
`timescale 1ns/1ps
`default_nettype none
module selfprog_flash_addr_map_tb;
  localparam int PROG = 20;
  logic pclk, presetn, sys_resetn, psel, penable, pwrite;
  logic pready, pslverr, eeprom_busy_in, apb_err;
  logic [1:0] boot_size_fuse;
  logic [7:0] paddr, lock_bits;
  logic [31:0] pwdata, prdata, rd_val;
  logic [14:0] boot_start;
  logic [14:0] boot_tab [4];
  int wofs [3];
  int miscompares, n_checks;
  sfam_if u_sfam_if ();
  sfam_device #(.PROG_CYCLES(PROG), .FLASH_WORDS(32768)) u_sfam_device (
    .pclk(pclk), .presetn(presetn), .sys_resetn(sys_resetn),
    .boot_size_fuse(boot_size_fuse), .link(u_sfam_if.device),
    .boot_start(boot_start), .lock_bits(lock_bits));
  sfam_core u_sfam_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eeprom_busy_in(eeprom_busy_in),
    .link(u_sfam_if.core));
  sfam_checker #(.PROG_CYCLES(PROG)) u_sfam_checker (
    .pclk(pclk), .presetn(presetn), .ctrl_wr(u_sfam_if.ctrl_wr),
    .ctrl_wdata(u_sfam_if.ctrl_wdata),
    .selfprog_ctrl_status_reg(u_sfam_if.selfprog_ctrl_status_reg),
    .store(u_sfam_if.store), .pointer(u_sfam_if.pointer),
    .fetch_data(u_sfam_if.fetch_data),
    .fetch_blocked(u_sfam_if.fetch_blocked),
    .eeprom_write_busy(u_sfam_if.eeprom_write_busy));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // =====
  // Tasks
  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Data and error are taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd_val = prdata;
    apb_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic cmd(input logic [15:0] p, input logic [31:0] d,
                     input logic [6:0] c);
    apb(1'h1, sfam_pkg::OFS_POINTER, {16'h0000, p});
    apb(1'h1, sfam_pkg::OFS_DATA, d);
    apb(1'h1, sfam_pkg::OFS_CMD, {25'h0, c});
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'h0, sfam_pkg::OFS_STATUS, 32'h0);
      if (rd_val[sfam_pkg::ST_BUSY] === 1'h0 &&
          u_sfam_if.selfprog_ctrl_status_reg[0] === 1'h0) break;
    end
    if (n >= 100) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic op(input logic [15:0] p, input logic [31:0] d,
                    input logic [6:0] c);
    cmd(p, d, c);
    wait_idle();
  endtask
  // One byte back, blocked flag in bit 16
  task automatic readw(input logic [15:0] p);
    apb(1'h1, sfam_pkg::OFS_POINTER, {16'h0000, p});
    apb(1'h0, sfam_pkg::OFS_READ, 32'h0);
  endtask
  // =====
  // Main sequence
  initial begin
    presetn = 1'h0;
    sys_resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    eeprom_busy_in = 1'h0;
    boot_size_fuse = 2'h0;
    miscompares = 0;
    n_checks = 0;
    boot_tab = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};
    wofs = '{0, 1, 127};
    for (int f = 0; f < 4; f++) begin
      @(posedge pclk);
      presetn <= 1'h0;
      boot_size_fuse <= 2'(f);
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      sys_resetn <= 1'h1;
      repeat (3) @(posedge pclk);
      cmp(boot_start, boot_tab[f]);
    end
    cmp(lock_bits, 32'hFF);
    apb(1'h1, 8'h20, 32'h0);
    cmp(apb_err, 32'h1);
    // Page 0x10: fill words, erase, write, re-enable, read back
    foreach (wofs[i]) op(16'h1000 | 16'(wofs[i] * 2), 32'hA500 + wofs[i],
                         sfam_pkg::CMD_LOAD);
    op(16'h1000, 32'h0, sfam_pkg::CMD_ERASE);
    op(16'h1000, 32'h0, sfam_pkg::CMD_WRITE);
    cmp(u_sfam_if.selfprog_ctrl_status_reg[6], 32'h1);
    readw(16'h1000);
    cmp(rd_val, 32'h0001_FFFF);
    cmp(rd_val[16], 32'h1);
    readw(16'hFC00);
    cmp(rd_val[16], 32'h0);
    op(16'h0000, 32'h0, sfam_pkg::CMD_REENABLE);
    cmp(u_sfam_if.selfprog_ctrl_status_reg[6], 32'h0);
    foreach (wofs[i]) begin
      readw(16'h1000 | 16'(wofs[i] * 2));
      cmp(rd_val, 32'(wofs[i]));
      readw(16'h1001 | 16'(wofs[i] * 2));
      cmp(rd_val, 32'hA5);
    end
    // Page 0x11: loaded word is dropped by re-enable
    op(16'h1100, 32'h1234, sfam_pkg::CMD_LOAD);
    op(16'h0000, 32'h0, sfam_pkg::CMD_REENABLE);
    op(16'h1100, 32'h0, sfam_pkg::CMD_ERASE);
    op(16'h1100, 32'h0, sfam_pkg::CMD_WRITE);
    op(16'h0000, 32'h0, sfam_pkg::CMD_REENABLE);
    readw(16'h1100);
    cmp(rd_val, 32'hFF);
    // System reset in mid-erase must not cut it short
    cmd(16'h1200, 32'h0, sfam_pkg::CMD_ERASE);
    repeat (4) @(posedge pclk);
    sys_resetn <= 1'h0;
    repeat (3) @(posedge pclk);
    sys_resetn <= 1'h1;
    @(posedge pclk);
    cmp(u_sfam_if.selfprog_ctrl_status_reg[0], 32'h1);
    wait_idle();
    op(16'h0000, 32'h0, sfam_pkg::CMD_REENABLE);
    // Command held back while the eeprom write runs
    @(posedge pclk);
    eeprom_busy_in <= 1'h1;
    cmd(16'h1200, 32'h0, sfam_pkg::CMD_ERASE);
    apb(1'h1, sfam_pkg::OFS_CMD, {25'h0, sfam_pkg::CMD_ERASE});
    cmp(apb_err, 32'h1);
    repeat (10) @(posedge pclk);
    cmp(u_sfam_if.selfprog_ctrl_status_reg[0], 32'h0);
    eeprom_busy_in <= 1'h0;
    wait_idle();
    cmp(u_sfam_if.selfprog_ctrl_status_reg[6], 32'h1);
    op(16'h0000, 32'h0, sfam_pkg::CMD_REENABLE);
    op(16'h0000, 32'hF3, sfam_pkg::CMD_LOCK);
    cmp(lock_bits, 32'hF3);
    complete_run();
  end
endmodule
`default_nettype wire
